// File: rtl/tft_panel_timing_generator.sv
/*
 TFT panel timing generator: APB register file, pixel clock with
 inversion and delay, line and frame sync, data enable, pixel bus.
 Assumes pixel_in comes from logic on ref_clk and APB on ref_clk.
*/
`timescale 1ns/1ps
module tft_panel_timing_generator
   import tft_timing_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire logic                     clk_en,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [PADDR_W-1:0]       paddr,
   input  wire logic [DATA_W-1:0]        pwdata,
   input  wire logic [STRB_W-1:0]        pstrb,
   output logic      [DATA_W-1:0]        prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [PIX_W-1:0]         pixel_in,
   output logic                          pixel_fetch,
   output logic                          pixel_clk_out,
   output logic                          hsync_out,
   output logic                          vsync_out,
   output logic                          pixel_valid_out,
   output logic      [PIX_W-1:0]         pixel_data_bus
);
   import tft_timing_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations

   // Register file
   logic [DATA_W-1:0]  ctrl_q;        // Display enable
   logic [DATA_W-1:0]  area_q;        // Active width and height
   logic [DATA_W-1:0]  hpar_q;        // Horizontal sync and porches
   logic [DATA_W-1:0]  vpar_q;        // Vertical sync and porches
   logic [DATA_W-1:0]  pol_q;         // Sync polarity select
   logic [DATA_W-1:0]  clkcfg_q;      // Pixel clock invert and delay

   // Bus decode
   logic               setup_ph;      // APB setup cycle
   logic               wr_take;       // Write committed this edge
   logic               addr_hit;      // Address is mapped
   logic [DATA_W-1:0]  rd_mux;        // Read value, selected
   logic [DATA_W-1:0]  prdata_q;      // Read data register
   logic               rd_valid_q;    // prdata_q holds this read

   // Configuration fields
   logic               run;           // Display enabled
   logic               pol_h;         // Line sync active-low
   logic               pol_v;         // Frame sync active-low
   logic               clk_inv;       // Invert pixel clock pin
   logic [DLY_W-1:0]   clk_dly;       // Pin delay; nonzero value gives value+1 ref cycles

   // Pixel clock
   logic               pclk_q;        // Internal pixel clock phase
   logic               pclk_nxt;      // Next internal phase
   logic [DLY_TAPS-1:0] dly_q;        // Delay line of the phase
   logic               pin_src;       // Selected tap
   logic               pclk_pin_q;    // Pixel clock pin register
   logic               pix_tick;      // Rising edge of pixel clock

   // Raster
   logic [CNT_W-1:0]   h_pos;         // Pixel within line
   logic [CNT_W-1:0]   v_pos;         // Line within frame
   logic               h_sync;        // In line sync
   logic               v_sync;        // In frame sync
   logic               h_act;         // In active columns
   logic               v_act;         // In active lines
   logic               h_last;        // Last pixel of line
   logic               v_last;        // Last line of frame
   logic               de_now;        // Active pixel this tick
   logic [FRM_W-1:0]   frame_q;       // Completed frames

   // Output registers
   logic               hsync_q;       // Line sync pin
   logic               vsync_q;       // Frame sync pin
   logic               de_q;          // Data enable pin
   logic [PIX_W-1:0]   data_q;        // Pixel data pins

   ////////////////////////////////////////////////////////////////////
   // Byte-lane merge of a write into a register
   function automatic logic [DATA_W-1:0] wr_merge
   (
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int b = 0; b < STRB_W; b++)
      begin
         if (strb[b])
            res[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return res;
   endfunction : wr_merge

   ////////////////////////////////////////////////////////////////////
   // APB slave

   // Setup cycle and committed write
   assign setup_ph = psel && !penable;
   assign wr_take  = psel && penable && pwrite && pready;

   // Address decode
   always_comb
   begin
      case (paddr)
         OFS_CTRL,
         OFS_AREA,
         OFS_HPAR,
         OFS_VPAR,
         OFS_POL,
         OFS_CLK,
         OFS_STATUS: addr_hit = 1'b1;
         default:    addr_hit = 1'b0;
      endcase
   end

   // Read multiplexer, status shows live raster state
   always_comb
   begin
      rd_mux = '0;
      case (paddr)
         OFS_CTRL:   rd_mux = ctrl_q;
         OFS_AREA:   rd_mux = area_q;
         OFS_HPAR:   rd_mux = hpar_q;
         OFS_VPAR:   rd_mux = vpar_q;
         OFS_POL:    rd_mux = pol_q;
         OFS_CLK:    rd_mux = clkcfg_q;
         OFS_STATUS:
         begin
            rd_mux[STAT_LINE_LSB +: CNT_W] = v_pos;
            rd_mux[STAT_VS_BIT]            = v_sync;
            rd_mux[STAT_DE_BIT]            = de_now;
            rd_mux[STAT_FRM_LSB +: FRM_W]  = frame_q;
         end
         default:    rd_mux = '0;
      endcase
   end

   // Reads wait until data is captured; frozen clock stalls bus
   assign pready  = clk_en && (pwrite || rd_valid_q);
   // Unmapped address answers with an error
   assign pslverr = psel && penable && pready && !addr_hit;
   assign prdata  = prdata_q;

   // Read data capture in the setup cycle
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_q   <= '0;
         rd_valid_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (psel && !pwrite && !rd_valid_q)
            prdata_q <= rd_mux;
         rd_valid_q <= psel && !pwrite && !(penable && rd_valid_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register file

   // Writes land at the access edge; reserved bits stay zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_q   <= RST_CTRL;
         area_q   <= RST_AREA;
         hpar_q   <= RST_HPAR;
         vpar_q   <= RST_VPAR;
         // [RULE_06] Active-high after reset
         pol_q    <= RST_POL;
         clkcfg_q <= RST_CLK;
      end
      else if (clk_en && wr_take)
      begin
         // [RULE_11] Timing set by software
         case (paddr)
            OFS_CTRL: ctrl_q   <= wr_merge(ctrl_q, pwdata, pstrb) & MSK_CTRL;
            OFS_AREA: area_q   <= wr_merge(area_q, pwdata, pstrb) & MSK_AREA;
            OFS_HPAR: hpar_q   <= wr_merge(hpar_q, pwdata, pstrb) & MSK_PAR;
            OFS_VPAR: vpar_q   <= wr_merge(vpar_q, pwdata, pstrb) & MSK_PAR;
            OFS_POL:  pol_q    <= wr_merge(pol_q, pwdata, pstrb) & MSK_POL;
            OFS_CLK:  clkcfg_q <= wr_merge(clkcfg_q, pwdata, pstrb) & MSK_CLK;
            default:  ctrl_q   <= ctrl_q;
         endcase
      end
   end

   // Field extraction
   assign run     = ctrl_q[CTRL_EN_BIT];
   assign pol_h   = pol_q[POL_H_BIT];
   assign pol_v   = pol_q[POL_V_BIT];
   assign clk_inv = clkcfg_q[CLK_INV_BIT];
   assign clk_dly = clkcfg_q[CLK_DLY_LSB +: DLY_W];

   ////////////////////////////////////////////////////////////////////
   // Pixel clock

   // [RULE_01] Free-running divide by two while enabled
   assign pclk_nxt = run ? !pclk_q : 1'b0;
   // Tick marks the edge at which the phase rises
   assign pix_tick = clk_en && run && !pclk_q;

   // Internal phase, parked low while disabled
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pclk_q <= 1'b0;
      else if (clk_en)
         pclk_q <= pclk_nxt;
   end

   // Delay line; tap k is the phase k+1 ref cycles late
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         dly_q <= '0;
      else if (clk_en)
         dly_q <= {dly_q[DLY_TAPS-2:0], pclk_q};
   end

   // [RULE_08] Delay tap select
   // Zero delay taps the next phase so pin and data align
   assign pin_src = (clk_dly == '0) ? pclk_nxt : dly_q[clk_dly - DLY_W'(1)];

   // Pin register; inversion samples data on the falling edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pclk_pin_q <= 1'b0;
      else if (clk_en)
         // [RULE_08] Optional clock inversion
         pclk_pin_q <= run && (pin_src ^ clk_inv);
   end

   assign pixel_clk_out = pclk_pin_q;

   ////////////////////////////////////////////////////////////////////
   // Raster counters

   // [RULE_09] Line counted in pixel clocks
   tft_axis_counter u_h_axis
   (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .run       (run),
      .step      (pix_tick),
      .sync_len  (hpar_q[PAR_SYNC_LSB +: FLD_W]),
      .bp_len    (hpar_q[PAR_BP_LSB +: FLD_W]),
      .act_len   (area_q[AREA_W_LSB +: SIZE_W]),
      .fp_len    (hpar_q[PAR_FP_LSB +: FLD_W]),
      .pos_q     (h_pos),
      .in_sync   (h_sync),
      .in_active (h_act),
      .last      (h_last)
   );

   // [RULE_10] Frame counted in whole lines
   // [RULE_13] Vertical order via counter
   tft_axis_counter u_v_axis
   (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .run       (run),
      .step      (pix_tick && h_last),
      .sync_len  (vpar_q[PAR_SYNC_LSB +: FLD_W]),
      .bp_len    (vpar_q[PAR_BP_LSB +: FLD_W]),
      .act_len   (area_q[AREA_H_LSB +: SIZE_W]),
      .fp_len    (vpar_q[PAR_FP_LSB +: FLD_W]),
      .pos_q     (v_pos),
      .in_sync   (v_sync),
      .in_active (v_act),
      .last      (v_last)
   );

   // [RULE_13] No enable outside active lines
   assign de_now = h_act && v_act;

   // Consumer handshake, one pulse per shown pixel
   assign pixel_fetch = pix_tick && de_now;

   // Completed frame count for software pacing
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         frame_q <= '0;
      else if (pix_tick && h_last && v_last)
         frame_q <= frame_q + FRM_W'(1);
   end

   ////////////////////////////////////////////////////////////////////
   // Panel outputs

   // [RULE_05] Update at pixel clock rise
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hsync_q <= 1'b0;
         vsync_q <= 1'b0;
         de_q    <= 1'b0;
         data_q  <= '0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            // Idle at the inactive sync levels
            hsync_q <= pol_h;
            vsync_q <= pol_v;
            de_q    <= 1'b0;
            data_q  <= '0;
         end
         else if (pix_tick)
         begin
            // [RULE_02] Sync lasts whole pixel clocks
            // [RULE_06] Polarity by exclusive or
            hsync_q <= h_sync ^ pol_h;
            // [RULE_03] Frame sync covers whole lines
            vsync_q <= v_sync ^ pol_v;
            // [RULE_07] Enable never inverted
            de_q    <= de_now;
            // [RULE_04] Data only with enable
            data_q  <= de_now ? pixel_in : '0;
         end
      end
   end

   assign hsync_out       = hsync_q;
   assign vsync_out       = vsync_q;
   assign pixel_valid_out = de_q;
   assign pixel_data_bus  = data_q;
endmodule : tft_panel_timing_generator

// File: rtl/tft_timing_pkg.sv
/*
 Constants, register map and reset values of the TFT panel timing
 generator. Assumes a 50 MHz ref_clk and 32-bit APB from software.
*/
// Overview of operation
// [RULE_01] Pixel clock runs continuously while display enabled
// [RULE_02] Line sync spans at least one pixel clock
// [RULE_03] Frame sync spans at least one line sync
// [RULE_04] Data enable qualifies pixel data as valid
// [RULE_05] Outputs change on pixel clock rising edge
// [RULE_06] Software sync polarity, active-high after reset
// [RULE_07] Data enable is always active-high
// [RULE_08] Pixel clock inversion and programmable delay
// [RULE_09] Line length is sync+porches+active width
// [RULE_10] Frame length is sync+porches+active height, lines
// [RULE_11] All horizontal and vertical timing software programmable
// [RULE_12] Line order: sync, back porch, active, front
// [RULE_13] Frame order: sync, back porch, active, front
package tft_timing_pkg;
   ////////////////////////////////////////////////////////////////////
   // Clocking
   localparam int unsigned REF_CLK_HZ  = 50_000_000; // ref_clk rate
   localparam int unsigned PCLK_MAX_HZ = 80_000_000; // panel limit
   localparam int unsigned PCLK_DIV    = 2;          // ref per pixel
   localparam int unsigned PCLK_HZ     = REF_CLK_HZ / PCLK_DIV;

   ////////////////////////////////////////////////////////////////////
   // Widths
   localparam int PADDR_W  = 8;   // APB byte address
   localparam int DATA_W   = 32;  // APB data
   localparam int STRB_W   = 4;   // byte strobes
   localparam int CNT_W    = 14;  // line and frame position
   localparam int FLD_W    = 10;  // sync and porch fields
   localparam int SIZE_W   = 12;  // active width and height
   localparam int PIX_W    = 24;  // pixel data bus
   localparam int DLY_W    = 3;   // clock delay field
   localparam int DLY_TAPS = 7;   // delay line depth
   localparam int FRM_W    = 16;  // frame counter

   ////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [PADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [PADDR_W-1:0] OFS_AREA   = 8'h04;
   localparam logic [PADDR_W-1:0] OFS_HPAR   = 8'h08;
   localparam logic [PADDR_W-1:0] OFS_VPAR   = 8'h0c;
   localparam logic [PADDR_W-1:0] OFS_POL    = 8'h10;
   localparam logic [PADDR_W-1:0] OFS_CLK    = 8'h14;
   localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h18;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_EN_BIT   = 0;
   localparam int AREA_W_LSB    = 0;
   localparam int AREA_H_LSB    = 16;
   localparam int PAR_SYNC_LSB  = 0;
   localparam int PAR_BP_LSB    = 10;
   localparam int PAR_FP_LSB    = 20;
   localparam int POL_H_BIT     = 0;
   localparam int POL_V_BIT     = 1;
   localparam int CLK_INV_BIT   = 0;
   localparam int CLK_DLY_LSB   = 4;
   localparam int STAT_LINE_LSB = 0;
   localparam int STAT_VS_BIT   = 14;
   localparam int STAT_DE_BIT   = 15;
   localparam int STAT_FRM_LSB  = 16;

   ////////////////////////////////////////////////////////////////////
   // Writable bits and reset values
   localparam logic [DATA_W-1:0] MSK_CTRL = 32'h0000_0001;
   localparam logic [DATA_W-1:0] MSK_AREA = 32'h0fff_0fff;
   localparam logic [DATA_W-1:0] MSK_PAR  = 32'h3fff_ffff;
   localparam logic [DATA_W-1:0] MSK_POL  = 32'h0000_0003;
   localparam logic [DATA_W-1:0] MSK_CLK  = 32'h0000_0071;
   localparam logic [DATA_W-1:0] RST_CTRL = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_AREA = 32'h01e0_0280;
   localparam logic [DATA_W-1:0] RST_HPAR = 32'h0100_c060;
   localparam logic [DATA_W-1:0] RST_VPAR = 32'h00a0_8402;
   localparam logic [DATA_W-1:0] RST_POL  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_CLK  = 32'h0000_0000;
endpackage : tft_timing_pkg

// File: rtl/tft_axis_counter.sv
/*
 One axis of the raster: counts sync, back porch, active, front
 porch. Assumes step is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ps
module tft_axis_counter
   import tft_timing_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire logic                     clk_en,
   input  wire logic                     run,
   input  wire logic                     step,
   input  wire logic [FLD_W-1:0]         sync_len,
   input  wire logic [FLD_W-1:0]         bp_len,
   input  wire logic [SIZE_W-1:0]        act_len,
   input  wire logic [FLD_W-1:0]         fp_len,
   output logic      [CNT_W-1:0]         pos_q,
   output logic                          in_sync,
   output logic                          in_active,
   output logic                          last
);
   import tft_timing_pkg::*;

   logic [CNT_W-1:0] sync_eff;   // Sync length, never zero
   logic [CNT_W-1:0] act_eff;    // Active length, never zero
   logic [CNT_W-1:0] act_start;  // First active position
   logic [CNT_W-1:0] act_end;    // First front porch position
   logic [CNT_W-1:0] total;      // Whole period

   // Zero sync would lose the pulse, so it counts as one
   always_comb
   begin
      sync_eff  = (sync_len == '0) ? CNT_W'(1) : CNT_W'(sync_len);
      act_eff   = (act_len == '0) ? CNT_W'(1) : CNT_W'(act_len);
      act_start = sync_eff + CNT_W'(bp_len);
      act_end   = act_start + act_eff;
      total     = act_end + CNT_W'(fp_len);
   end

   // [RULE_12] Sync, porch, active order
   assign in_sync   = pos_q < sync_eff;
   assign in_active = (pos_q >= act_start) && (pos_q < act_end);
   // [RULE_09] Period is the sum
   assign last      = pos_q >= (total - CNT_W'(1));

   // Position counter, wraps early if shortened on the fly
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pos_q <= '0;
      else if (clk_en)
      begin
         if (!run)
            pos_q <= '0;
         else if (step)
            pos_q <= last ? '0 : pos_q + CNT_W'(1);
      end
   end
endmodule : tft_axis_counter

// File: testbench/tft_timing_assertions.sv
/*
 Port checker for the panel timing generator.
 Assumes one ref_clk domain; bound to the top below.
*/
`timescale 1ns/1ps
module tft_timing_assertions
   import tft_timing_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              clk_en,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [STRB_W-1:0] pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [PIX_W-1:0]  pixel_in,
   input wire logic              pixel_fetch,
   input wire logic              pixel_clk_out,
   input wire logic              hsync_out,
   input wire logic              vsync_out,
   input wire logic              pixel_valid_out,
   input wire logic [PIX_W-1:0]  pixel_data_bus
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic wr_acc; // Register write in access phase; lands this edge only with clk_en high
   assign wr_acc = psel && penable && pwrite;
   ////////////////////////////////////////////////////////////////////
   // Panel side
   a_pclk_toggle: assert property (clk_en && pixel_clk_out |=> !pixel_clk_out)
      else $error("pixel clock stuck high");
   a_hsync_hold: assert property ($changed(hsync_out) && !$past(wr_acc) |=> $stable(hsync_out))
      else $error("line sync shorter than a pixel");
   a_vsync_hold: assert property ($changed(vsync_out) && !$past(wr_acc) |=> $stable(vsync_out))
      else $error("frame sync shorter than a pixel");
   a_valid_hold: assert property ($changed(pixel_valid_out) && !$past(wr_acc) |=> $stable(pixel_valid_out))
      else $error("data enable changed mid pixel");
   // Fetched word shows on the bus with enable high
   a_fetch_data: assert property (pixel_fetch && clk_en && !wr_acc |=>
      pixel_valid_out && pixel_data_bus == $past(pixel_in))
      else $error("fetched pixel not presented");
   a_idle_data: assert property (!pixel_valid_out |-> pixel_data_bus == '0)
      else $error("data not cleared outside enable");
   a_fetch_pulse: assert property (pixel_fetch && clk_en |=> !pixel_fetch)
      else $error("fetch longer than one cycle");
   ////////////////////////////////////////////////////////////////////
   // Register bus
   a_write_ready: assert property (wr_acc |-> pready == clk_en)
      else $error("write wait state wrong");
   a_read_ready: assert property (psel && !penable && !pwrite && clk_en ##1 penable && clk_en |-> pready)
      else $error("read not done in one access");
   a_err_map: assert property (psel && penable && pready |->
      pslverr == (paddr > OFS_STATUS || paddr[1:0] != 2'h0))
      else $error("error flag disagrees with map");
   c_fetch: cover property (pixel_fetch);
   c_error: cover property (pslverr);
   c_valid: cover property ($rose(pixel_valid_out));
endmodule : tft_timing_assertions

bind tft_panel_timing_generator tft_timing_assertions u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixel_in(pixel_in),
   .pixel_fetch(pixel_fetch), .pixel_clk_out(pixel_clk_out), .hsync_out(hsync_out),
   .vsync_out(vsync_out), .pixel_valid_out(pixel_valid_out), .pixel_data_bus(pixel_data_bus));

// File: testbench/tft_panel_model.sv
/*
 Behavioural TFT panel: latches on pixel clock fall and measures
 line and frame geometry. Assumes no clock inversion or delay.
*/
`timescale 1ns/1ps
module tft_panel_model
   import tft_timing_pkg::*;
(
   input wire logic             pixel_clk_out,
   input wire logic             hsync_out,
   input wire logic             vsync_out,
   input wire logic             pixel_valid_out,
   input wire logic [PIX_W-1:0] pixel_data_bus,
   input wire logic [1:0]       pol,
   output int                   res [10]
);
   logic h, v, d, hp, vp, seen; // Latched pins, edge history
   logic [PIX_W-1:0] px, lastpx; // Latched and previous pixel
   int hpos, hc, dc, vl, vc, dr, pix;
   initial {hp, vp, seen, hpos, hc, dc, vl, vc, dr, pix} = '0;
   initial res = '{default: 0};
   // Latch mid-period, so the rise sees the previous pixel
   always @(negedge pixel_clk_out)
      {h, v, d, px} = {hsync_out ^ pol[0], vsync_out ^ pol[1], pixel_valid_out, pixel_data_bus};
   // Measure on each rise: 0 line,1 hs,2 de offset,3 de,4 lines,5 vs,6 de row,7 rows,8 pixels,9 bad data
   always @(posedge pixel_clk_out)
   begin
      if (h && !hp)
      begin
         res[0] = hpos; res[1] = hc;
         if (dc != 0) res[3] = dc;
         hpos = 0; hc = 0; dc = 0;
         if (v && !vp)
         begin
            res[4] = vl; res[5] = vc; res[7] = dr; res[8] = pix;
            vl = 0; vc = 0; dr = 0; pix = 0;
         end
         vl++;
         if (v) vc++;
         vp = v;
      end
      hp = h;
      if (d)
      begin
         if (dc == 0)
         begin
            res[2] = hpos; dr++;
            if (dr == 1) res[6] = vl;
         end
         // Words must arrive in fetch order
         if (seen && px !== lastpx + 24'h1) res[9]++;
         {seen, lastpx} = {1'b1, px};
         dc++; pix++;
      end
      if (h) hc++;
      hpos++;
   end
endmodule : tft_panel_model

// File: testbench/tb_tft_panel_timing_generator.sv
/*
 Self-checking bench: APB register checks, then raster runs
 measured by the panel model. Assumes the checker is bound.
*/
`timescale 1ns/1ps
module tb_tft_panel_timing_generator;
   import tft_timing_pkg::*;
   localparam int HS = 2, HB = 1, HA = 5, HF = 1; // Small line
   localparam int VS = 1, VB = 1, VA = 2, VF = 1; // Small frame
   logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0]  pwdata = '0, prdata;
   logic [STRB_W-1:0]  pstrb = 4'hf;
   logic pready, pslverr, pixel_fetch, pixel_clk_out, hsync_out, vsync_out, pixel_valid_out;
   logic [PIX_W-1:0]   pixel_in = '0, pixel_data_bus;
   logic [1:0]         pol = 2'b00; // Panel's view of polarity
   int res [10];
   int error_cnt = 0;
   int num_checks = 0;

   always #10 ref_clk = ~ref_clk;

   tft_panel_timing_generator DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pixel_in(pixel_in), .pixel_fetch(pixel_fetch),
      .pixel_clk_out(pixel_clk_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
      .pixel_valid_out(pixel_valid_out), .pixel_data_bus(pixel_data_bus));
   tft_panel_model u_panel (.pixel_clk_out(pixel_clk_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
      .pixel_valid_out(pixel_valid_out), .pixel_data_bus(pixel_data_bus), .pol(pol), .res(res));

   // Pixel source: next word after each fetch
   always @(posedge ref_clk)
      if (pixel_fetch && clk_en) pixel_in <= pixel_in + 24'h1;
   ////////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One APB transfer; waits an edge first so release never meets setup
   task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rd, output logic err);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         error_cnt++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      check({31'h0, e}, 32'h0);
   endtask : wr
   task automatic rd(input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic xe);
      logic [DATA_W-1:0] r;
      logic e;
      apb(1'b0, a, '0, r, e);
      check(r, exp);
      check({31'h0, e}, {31'h0, xe});
   endtask : rd
   ////////////////////////////////////////////////////////////////////
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      end_of_test();
   end
   // Main sequence
   initial
   begin
      logic [DATA_W-1:0] rtab [6];
      logic [DATA_W-1:0] hpar;
      int exp [10];
      rtab = '{RST_CTRL, RST_AREA, RST_HPAR, RST_VPAR, RST_POL, RST_CLK};
      hpar = 32'((HF << PAR_FP_LSB) | (HB << PAR_BP_LSB) | HS);
      exp = '{HS+HB+HA+HF, HS, HS+HB, HA, VS+VB+VA+VF, VS, VS+VB+1, VA, HA*VA, 0};
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd(8'(i * 4), rtab[i], 1'b0);
      rd(8'h1c, 32'h0, 1'b1);
      wr(OFS_CLK, 32'hffff_ffff);
      rd(OFS_CLK, MSK_CLK, 1'b0);
      wr(OFS_CLK, RST_CLK);
      wr(OFS_AREA, 32'((VA << AREA_H_LSB) | HA));
      wr(OFS_HPAR, hpar & 32'hffff_ff00);
      pstrb <= 4'h1;
      wr(OFS_HPAR, 32'hffff_ff00 | 32'(HS));
      pstrb <= 4'hf;
      rd(OFS_HPAR, hpar, 1'b0);
      wr(OFS_VPAR, 32'((VF << PAR_FP_LSB) | (VB << PAR_BP_LSB) | VS));
      // Run once per sync polarity
      for (int p = 0; p < 2; p++)
      begin
         pol <= p ? 2'b11 : 2'b00;
         wr(OFS_POL, p ? 32'h3 : 32'h0);
         repeat (4) @(posedge ref_clk);
         check({30'h0, hsync_out, vsync_out}, p ? 32'h3 : 32'h0);
         wr(OFS_CTRL, 32'h1);
         repeat (150) @(posedge ref_clk);
         clk_en <= 1'b0;
         repeat (5) @(posedge ref_clk);
         clk_en <= 1'b1;
         repeat (200) @(posedge ref_clk);
         for (int i = 0; i < 10; i++)
            check(32'(res[i]), 32'(exp[i]));
         wr(OFS_CTRL, 32'h0);
         repeat (4) @(posedge ref_clk);
         check({30'h0, pixel_valid_out, pixel_clk_out}, 32'h0);
      end
      end_of_test();
   end
endmodule : tb_tft_panel_timing_generator
